// >>> hdl/fpga_cfg_pkg.sv
// constants, types and helpers shared by the configuration pin controller
package fpga_cfg_pkg;

	localparam int REF_HZ   = 10_000_000;
	localparam int TICK_HZ  = 1_000_000;
	localparam int TICK_DIV = REF_HZ / TICK_HZ;
	localparam logic [3:0] TICK_LAST = 4'(TICK_DIV - 1);

	localparam int POR_EXP_HI = 14;
	localparam int POR_EXP_LO = 16;
	localparam int POR_TICKS_HI = 2 ** POR_EXP_HI;
	localparam int POR_TICKS_LO = 2 ** POR_EXP_LO;

	localparam logic [1:0] DONE_HOLD_LAST = 2'h1;
	localparam logic [4:0] CLEAR_LAST     = 5'h0f;
	localparam logic [2:0] BYTE_LAST      = 3'h7;

	localparam logic [15:0] ADDR_LOW_START  = 16'h0000;
	localparam logic [15:0] ADDR_HIGH_START = 16'hffff;
	localparam int PIN_W = 20;

	typedef enum logic [2:0]
	{
		MODE_MSER   = 3'h0,
		MODE_MLOW   = 3'h4,
		MODE_PERIPH = 3'h5,
		MODE_MHIGH  = 3'h6,
		MODE_SSER   = 3'h7
	} mode_t;

	typedef enum logic [1:0]
	{
		RB_OFF  = 2'h0,
		RB_ONCE = 2'h1,
		RB_MANY = 2'h2
	} rb_opt_t;

	typedef enum logic [3:0]
	{
		S_POR    = 4'h0,
		S_CLEAR  = 4'h1,
		S_HOLD   = 4'h3,
		S_LOAD   = 4'h2,
		S_START1 = 4'h6,
		S_START2 = 4'h7,
		S_USER   = 4'h5,
		S_PDOWN  = 4'h4,
		S_RESUME = 4'hc
	} state_t;

	typedef struct packed
	{
		logic [2:0] sel_n;
		logic       ws;
		logic [7:0] data;
	} periph_bus_t;

	function automatic logic drivesCclk(input mode_t m);
		return m != MODE_SSER;
	endfunction

	function automatic logic isParMaster(input mode_t m);
		return (m == MODE_MLOW) || (m == MODE_MHIGH);
	endfunction

	function automatic logic isSerial(input mode_t m);
		return (m == MODE_SSER) || (m == MODE_MSER);
	endfunction

endpackage

// >>> hdl/fpga_config_pin_control.sv
// configuration loader and control-pin logic of the gate array
//
// Summary of operation
// [R1] power-down low halts, resets, tri-states everything
// [R2] after power-down, done stays low two ticks
// [R3] power-down held high during configuration
// [R4] reset low postpones configuration start
// [R5] timeout then reset release, sample modes
// [R6] reset during load reinitializes and restarts
// [R7] reset after configuration clears storage elements
// [R8] drive config clock in master, peripheral
// [R9] external config clock parked high, short lows
// [R10] startup ordered; done before or after outputs
// [R11] done falling edge after configuration reconfigures
// [R12] mode0 picks power-on delay length
// [R13] read-trigger rising edge starts readback
// [R14] readback data active low on mode1
// [R15] config flags held until configuration completes
// [R16] init low while stabilizing and clearing
// [R17] peripheral write latches byte on deassertion
// [R18] ready/busy shows when byte accepted
// [R19] master parallel drives sixteen-bit address
// [R20] address clock rises before address changes
// [R21] serial data in, forwarded out downstream
// [R22] pull-ups on, unused outputs tri-stated
// [R23] mode latched once per attempt
`timescale 1ns/100ps
module fpga_config_pin_control #(
	parameter int POR_TICKS_HI = fpga_cfg_pkg::POR_TICKS_HI,
	parameter int POR_TICKS_LO = fpga_cfg_pkg::POR_TICKS_LO
) (
	input  wire logic                        ref_clk,
	input  wire logic                        nrst,
	input  wire logic                        power_down_n,
	input  wire logic                        configReset_n,
	input  wire logic                        config_clock_in,
	input  wire logic                        done_program_in,
	input  wire logic                        mode0_read_trigger,
	input  wire logic                        mode1_readback_data_in,
	input  wire logic                        mode2_select,
	input  wire fpga_cfg_pkg::periph_bus_t   periphIn,
	input  wire logic                        serialDataIn,
	input  wire logic                        cfgLoadDone,
	input  wire logic                        readbackBit,
	input  wire logic                        readbackLast,
	input  wire logic                        doneBeforeOutputs,
	input  wire fpga_cfg_pkg::rb_opt_t       readbackOption,
	output logic                             config_clock_out,
	output logic                             config_clock_oe,
	output logic                             done_program_oe,
	output logic                             mode1_readback_data_out,
	output logic                             mode1_readback_data_oe,
	output logic                             config_high_flag,
	output logic                             config_low_flag,
	output logic                             configFlagsOe,
	output logic                             initLowOe,
	output logic                             readyBusy,
	output logic                             readyBusyOe,
	output logic                             addrClock,
	output logic                             addrClockOe,
	output logic [15:0]                      memory_address_out,
	output logic                             memAddrOe,
	output logic                             write_strobe_out,
	output logic                             periph_select2_n_out,
	output logic                             serialDataOut,
	output logic                             serialDataOe,
	output logic                             pullupEn,
	output logic                             cfgBit,
	output logic                             cfgBitValid,
	output logic                             readbackShift,
	output logic                             outputsActive,
	output logic                             storageReset
);
	////////////////////////////////////////////////////////////////////////////
	// pin synchronisation
	logic [fpga_cfg_pkg::PIN_W-1:0] rawPins;
	logic [fpga_cfg_pkg::PIN_W-1:0] syncPins;
	logic [fpga_cfg_pkg::PIN_W-1:0] pins;
	logic                           pdn;
	logic                           rstPin;
	logic                           cclkPin;
	logic                           donePin;
	logic [2:0]                     modePins;
	logic                           serPin;
	fpga_cfg_pkg::periph_bus_t      bus;

	assign rawPins = {power_down_n, configReset_n, config_clock_in, done_program_in,
		mode2_select, mode1_readback_data_in, mode0_read_trigger, periphIn, serialDataIn};

	pin_sync3 #(.W(fpga_cfg_pkg::PIN_W)) pinSync (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.pinIn   (rawPins),
		.pinOut  (syncPins)
	);

	assign pdn = syncPins[fpga_cfg_pkg::PIN_W-1];
	// while powered down every input reads as high
	assign pins = pdn ? syncPins : '1; // see [R1]
	assign rstPin   = pins[18];
	assign cclkPin  = pins[17];
	assign donePin  = pins[16];
	assign modePins = pins[15:13];
	assign bus      = pins[12:1];
	assign serPin   = pins[0];

	////////////////////////////////////////////////////////////////////////////
	// 1 MHz tick
	logic [3:0] divCnt_q;
	logic       tick_q;

	always_ff @(posedge ref_clk)
	begin
		if (!nrst || !pdn)
		begin
			divCnt_q <= 4'h0;
			tick_q   <= 1'b0;
		end
		else
		begin
			tick_q   <= divCnt_q == fpga_cfg_pkg::TICK_LAST;
			divCnt_q <= (divCnt_q == fpga_cfg_pkg::TICK_LAST) ? 4'h0 : divCnt_q + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sequencing
	fpga_cfg_pkg::state_t state_q;
	fpga_cfg_pkg::mode_t  mode_q;
	logic [16:0]          porCnt_q;
	logic [16:0]          porLast;
	logic                 porSampled_q;
	logic                 porLong_q;
	logic [4:0]           clrCnt_q;
	logic [1:0]           holdCnt_q;
	logic                 configured_q;
	logic                 donePrev_q;
	logic                 inLoad;
	logic                 preUser;

	assign porLast = porLong_q ? 17'(POR_TICKS_LO - 1) : 17'(POR_TICKS_HI - 1);
	assign inLoad  = state_q == fpga_cfg_pkg::S_LOAD;
	// start-up steps count as done, so flags never overlap active outputs
	assign preUser = (state_q == fpga_cfg_pkg::S_POR) || (state_q == fpga_cfg_pkg::S_CLEAR)
		|| (state_q == fpga_cfg_pkg::S_HOLD) || inLoad;

	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
			state_q <= fpga_cfg_pkg::S_POR;
		else if (!pdn && state_q != fpga_cfg_pkg::S_PDOWN)
			state_q <= fpga_cfg_pkg::S_PDOWN; // see [R1]
		else
		begin
			unique case (state_q)
				fpga_cfg_pkg::S_POR:
					if (tick_q && porSampled_q && porCnt_q == porLast)
						state_q <= fpga_cfg_pkg::S_CLEAR; // see [R5]
				fpga_cfg_pkg::S_CLEAR:
					if (tick_q && clrCnt_q == fpga_cfg_pkg::CLEAR_LAST)
						state_q <= fpga_cfg_pkg::S_HOLD;
				fpga_cfg_pkg::S_HOLD:
					if (rstPin)
						state_q <= fpga_cfg_pkg::S_LOAD; // see [R4] [R5]
				fpga_cfg_pkg::S_LOAD:
					if (!rstPin)
						state_q <= fpga_cfg_pkg::S_CLEAR; // see [R6]
					else if (cfgLoadDone)
						state_q <= fpga_cfg_pkg::S_START1;
				fpga_cfg_pkg::S_START1:
					if (tick_q)
						state_q <= fpga_cfg_pkg::S_START2;
				fpga_cfg_pkg::S_START2:
					if (tick_q)
						state_q <= fpga_cfg_pkg::S_USER;
				fpga_cfg_pkg::S_USER:
					if (donePrev_q && !donePin)
						state_q <= fpga_cfg_pkg::S_CLEAR; // see [R11]
				fpga_cfg_pkg::S_PDOWN:
					// a power-down before configuration is illegal; restart cleanly
					if (pdn)
						state_q <= configured_q ? fpga_cfg_pkg::S_RESUME : fpga_cfg_pkg::S_CLEAR;
				fpga_cfg_pkg::S_RESUME:
					if (tick_q && holdCnt_q == fpga_cfg_pkg::DONE_HOLD_LAST)
						state_q <= fpga_cfg_pkg::S_USER; // see [R2]
				default:
					state_q <= fpga_cfg_pkg::S_POR;
			endcase
		end
	end

	// mode0 sampled at the first tick, once the synchroniser has settled
	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
		begin
			porSampled_q <= 1'b0;
			porLong_q    <= 1'b0;
			porCnt_q     <= 17'h00000;
		end
		else if (state_q != fpga_cfg_pkg::S_POR)
			porCnt_q <= 17'h00000;
		else if (tick_q && !porSampled_q)
		begin
			porSampled_q <= 1'b1;
			porLong_q    <= !modePins[0]; // see [R12]
		end
		else if (tick_q)
			porCnt_q <= porCnt_q + 17'h00001;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!nrst || state_q != fpga_cfg_pkg::S_CLEAR)
			clrCnt_q <= 5'h00;
		else if (tick_q)
			clrCnt_q <= clrCnt_q + 5'h01;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!nrst || state_q != fpga_cfg_pkg::S_RESUME)
			holdCnt_q <= 2'h0;
		else if (tick_q)
			holdCnt_q <= holdCnt_q + 2'h1;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
		begin
			configured_q <= 1'b0;
			donePrev_q   <= 1'b1;
		end
		else
		begin
			donePrev_q <= donePin;
			if (state_q == fpga_cfg_pkg::S_USER)
				configured_q <= 1'b1;
			else if (state_q == fpga_cfg_pkg::S_CLEAR)
				configured_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// mode capture and configuration clock
	logic [15:0] addr_q;
	logic        cclkOut_q;
	logic        cclkPrev_q;
	logic        drv;
	logic        cclkRise;
	logic        extRise;

	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
			mode_q <= fpga_cfg_pkg::MODE_SSER;
		else if (state_q == fpga_cfg_pkg::S_HOLD && rstPin)
			mode_q <= fpga_cfg_pkg::mode_t'(modePins); // see [R23]
	end

	assign drv     = fpga_cfg_pkg::drivesCclk(mode_q);
	assign extRise = cclkPin && !cclkPrev_q;
	assign cclkRise = drv ? (tick_q && !cclkOut_q) : extRise;

	// driven clock runs at half the tick rate and parks high
	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
		begin
			cclkOut_q  <= 1'b1;
			cclkPrev_q <= 1'b1;
		end
		else
		begin
			cclkPrev_q <= cclkPin;
			if (inLoad && drv && tick_q)
				cclkOut_q <= !cclkOut_q; // see [R8]
			else if (!inLoad)
				cclkOut_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// data entry
	logic       wrOn;
	logic       wrPrev_q;
	logic       latchByte;
	logic [7:0] buf_q;
	logic       bufFull_q;
	logic [7:0] sh_q;
	logic [2:0] cnt_q;
	logic       shifting_q;
	logic       serial;
	logic       periph;
	logic       byteReady;
	logic [7:0] nextByte;
	logic       emit;
	logic       take;
	logic       bitVal;
	logic       advPend_q;
	logic       rclk_q;

	assign serial    = fpga_cfg_pkg::isSerial(mode_q);
	assign periph    = mode_q == fpga_cfg_pkg::MODE_PERIPH;
	assign wrOn      = (bus.sel_n == 3'h0) && bus.ws;
	assign latchByte = inLoad && periph && wrPrev_q && !wrOn; // see [R17]
	assign byteReady = periph ? bufFull_q : fpga_cfg_pkg::isParMaster(mode_q);
	assign nextByte  = periph ? buf_q : bus.data;
	assign emit      = inLoad && cclkRise && (serial || shifting_q || byteReady);
	assign take      = emit && !serial && !shifting_q;
	assign bitVal    = serial ? serPin : (shifting_q ? sh_q[7] : nextByte[7]); // see [R21]

	always_ff @(posedge ref_clk)
	begin
		if (!nrst || !inLoad)
		begin
			wrPrev_q  <= 1'b0;
			bufFull_q <= 1'b0;
			buf_q     <= 8'h00;
		end
		else
		begin
			wrPrev_q <= wrOn;
			if (latchByte)
			begin
				buf_q     <= bus.data;
				bufFull_q <= 1'b1;
			end
			else if (take)
				bufFull_q <= 1'b0;
		end
	end

	// bytes go out msb first, one bit per clock rise
	always_ff @(posedge ref_clk)
	begin
		if (!nrst || !inLoad)
		begin
			sh_q       <= 8'h00;
			cnt_q      <= 3'h0;
			shifting_q <= 1'b0;
		end
		else if (emit && !serial)
		begin
			if (!shifting_q)
			begin
				sh_q       <= {nextByte[6:0], 1'b0};
				cnt_q      <= fpga_cfg_pkg::BYTE_LAST - 3'h1;
				shifting_q <= 1'b1;
			end
			else
			begin
				sh_q       <= {sh_q[6:0], 1'b0};
				cnt_q      <= cnt_q - 3'h1;
				shifting_q <= cnt_q != 3'h0;
			end
		end
	end

	// address only moves on a later tick, so the clock edge always leads it
	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
		begin
			addr_q    <= fpga_cfg_pkg::ADDR_LOW_START;
			advPend_q <= 1'b0;
			rclk_q    <= 1'b0;
		end
		else if (state_q == fpga_cfg_pkg::S_HOLD)
		begin
			addr_q    <= (modePins == fpga_cfg_pkg::MODE_MHIGH)
				? fpga_cfg_pkg::ADDR_HIGH_START : fpga_cfg_pkg::ADDR_LOW_START; // see [R19]
			advPend_q <= 1'b0;
			rclk_q    <= 1'b0;
		end
		else if (take && fpga_cfg_pkg::isParMaster(mode_q))
		begin
			rclk_q    <= 1'b1; // see [R20]
			advPend_q <= 1'b1;
		end
		else if (advPend_q && tick_q)
		begin
			addr_q    <= (mode_q == fpga_cfg_pkg::MODE_MHIGH) ? addr_q - 16'h0001
				: addr_q + 16'h0001;
			advPend_q <= 1'b0;
			rclk_q    <= 1'b0;
		end
	end

	logic       cfgBit_q;
	logic       cfgBitValid_q;
	logic       serOut_q;
	logic       rdy_q;

	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
		begin
			cfgBit_q      <= 1'b0;
			cfgBitValid_q <= 1'b0;
			serOut_q      <= 1'b1;
			rdy_q         <= 1'b0;
		end
		else
		begin
			cfgBitValid_q <= emit;
			rdy_q         <= inLoad && !bufFull_q && !latchByte; // see [R18]
			if (emit)
			begin
				cfgBit_q <= bitVal;
				serOut_q <= bitVal; // see [R21]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// startup, readback and pin ownership
	logic doneOe_q;
	logic outAct_q;
	logic rbTrigPrev_q;
	logic rbActive_q;
	logic rbUsed_q;
	logic rbShift_q;
	logic rdata_q;
	logic rbStart;
	logic inUser;
	logic startTick;

	assign inUser    = state_q == fpga_cfg_pkg::S_USER;
	assign startTick = tick_q && (state_q == fpga_cfg_pkg::S_START1
		|| state_q == fpga_cfg_pkg::S_START2);

	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
		begin
			doneOe_q <= 1'b1;
			outAct_q <= 1'b0;
		end
		else if (inUser)
		begin
			doneOe_q <= 1'b0;
			outAct_q <= 1'b1;
		end
		else if (state_q == fpga_cfg_pkg::S_PDOWN)
		begin
			doneOe_q <= 1'b0; // see [R1]
			outAct_q <= 1'b0;
		end
		else if (state_q == fpga_cfg_pkg::S_RESUME)
		begin
			doneOe_q <= 1'b1; // see [R2]
			outAct_q <= 1'b1;
		end
		else if (startTick)
		begin
			if (state_q == fpga_cfg_pkg::S_START2 || doneBeforeOutputs)
				doneOe_q <= 1'b0; // see [R10]
			if (state_q == fpga_cfg_pkg::S_START2 || !doneBeforeOutputs)
				outAct_q <= 1'b1; // see [R10]
		end
		else if (state_q != fpga_cfg_pkg::S_START1 && state_q != fpga_cfg_pkg::S_START2)
		begin
			doneOe_q <= 1'b1;
			outAct_q <= 1'b0;
		end
	end

	// the external clock is assumed parked high and never held low for long
	assign rbStart = inUser && modePins[0] && !rbTrigPrev_q // see [R13]
		&& (readbackOption == fpga_cfg_pkg::RB_MANY
		|| (readbackOption == fpga_cfg_pkg::RB_ONCE && !rbUsed_q));

	always_ff @(posedge ref_clk)
	begin
		if (!nrst || !inUser)
		begin
			rbTrigPrev_q <= 1'b1;
			rbActive_q   <= 1'b0;
			rbShift_q    <= 1'b0;
			rdata_q      <= 1'b1;
		end
		else
		begin
			rbTrigPrev_q <= modePins[0];
			rbShift_q    <= rbActive_q && extRise; // see [R9]
			if (rbStart)
				rbActive_q <= 1'b1;
			else if (rbActive_q && extRise && readbackLast)
				rbActive_q <= 1'b0;
			if (rbActive_q && extRise)
				rdata_q <= !readbackBit; // see [R14]
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!nrst || state_q == fpga_cfg_pkg::S_CLEAR)
			rbUsed_q <= 1'b0;
		else if (rbStart)
			rbUsed_q <= 1'b1;
	end

	logic flagsOe_q;
	logic initOe_q;
	logic pullup_q;
	logic stRst_q;
	logic rdataOe_q;
	logic cclkOe_q;
	logic rdyOe_q;
	logic parOe_q;
	logic serOe_q;

	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
		begin
			flagsOe_q <= 1'b1;
			initOe_q  <= 1'b1;
			pullup_q  <= 1'b1;
			stRst_q   <= 1'b1;
			rdataOe_q <= 1'b0;
		end
		else
		begin
			flagsOe_q <= preUser; // see [R15]
			initOe_q  <= state_q == fpga_cfg_pkg::S_POR
				|| state_q == fpga_cfg_pkg::S_CLEAR; // see [R16]
			pullup_q  <= preUser; // see [R22]
			stRst_q   <= (inUser && !rstPin) || !inUser && !outAct_q; // see [R7]
			rdataOe_q <= rbActive_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs, each from a flip-flop; unused pins stay tri-stated
	assign config_clock_out        = cclkOut_q;
	assign config_clock_oe         = cclkOe_q;
	assign done_program_oe         = doneOe_q;
	assign mode1_readback_data_out = rdata_q;
	assign mode1_readback_data_oe  = rdataOe_q;
	assign config_high_flag        = flagsOe_q;
	assign config_low_flag         = !flagsOe_q;
	assign configFlagsOe           = flagsOe_q;
	assign initLowOe               = initOe_q;
	assign readyBusy               = rdy_q;
	assign readyBusyOe             = rdyOe_q;
	assign addrClock               = rclk_q;
	assign addrClockOe             = parOe_q;
	assign memory_address_out      = addr_q;
	assign memAddrOe               = parOe_q;
	assign write_strobe_out        = addr_q[0];
	assign periph_select2_n_out    = addr_q[1];
	assign serialDataOut           = serOut_q;
	assign serialDataOe            = serOe_q;
	assign pullupEn                = pullup_q;
	assign cfgBit                  = cfgBit_q;
	assign cfgBitValid             = cfgBitValid_q;
	assign readbackShift           = rbShift_q;
	assign outputsActive           = outAct_q;
	assign storageReset            = stRst_q;

	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
		begin
			cclkOe_q <= 1'b0;
			rdyOe_q  <= 1'b0;
			parOe_q  <= 1'b0;
			serOe_q  <= 1'b0;
		end
		else
		begin
			cclkOe_q <= inLoad && drv; // see [R8] [R22]
			rdyOe_q  <= inLoad && periph; // see [R18]
			parOe_q  <= inLoad && fpga_cfg_pkg::isParMaster(mode_q); // see [R19]
			serOe_q  <= inLoad; // see [R21]
		end
	end
endmodule

// >>> hdl/pin_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module pin_sync3 #(
	parameter int W = 1
) (
	input  wire logic         ref_clk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] pinIn,
	output logic      [W-1:0] pinOut
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] out_q;

	// reset to ones: undriven pins sit on their pull-ups
	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
		begin
			s1_q  <= '1;
			s2_q  <= '1;
			s3_q  <= '1;
			out_q <= '1;
		end
		else
		begin
			s1_q  <= pinIn;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			out_q <= (s2_q & s3_q) | (out_q & (s2_q | s3_q));
		end
	end

	assign pinOut = out_q;
endmodule

// >>> tb/cfg_source_model.sv
// slave-mode configuration source: external clock bursts and serial data
`timescale 1ns/100ps
module cfg_source_model (
	input  wire logic        go,
	input  wire logic [7:0]  nRises,
	input  wire logic [15:0] pattern,
	output logic             cclkExt,
	output logic             serialDataIn
);
	logic [3:0] idx;
	initial
	begin
		cclkExt = 1'b1;
		serialDataIn = 1'b1;
		idx = 4'h0;
	end
	// parked high between frames; lows far below the limit
	always @(posedge go)
	begin
		#37;
		repeat (nRises)
		begin
			cclkExt = 1'b0;
			serialDataIn = pattern[4'hf - idx];
			idx = idx + 4'h1;
			#400 cclkExt = 1'b1;
			#400;
		end
		// released line inverts to catch late samples
		serialDataIn = ~serialDataIn;
	end
endmodule

// >>> tb/fpga_config_pin_control_props.sv
// port assertions for the configuration pin controller
`timescale 1ns/100ps
module fpga_config_pin_control_props (
	input wire logic        ref_clk,
	input wire logic        nrst,
	input wire logic        power_down_n,
	input wire logic        configReset_n,
	input wire logic        readbackBit,
	input wire logic        config_clock_oe,
	input wire logic        done_program_oe,
	input wire logic        mode1_readback_data_out,
	input wire logic        mode1_readback_data_oe,
	input wire logic        config_high_flag,
	input wire logic        config_low_flag,
	input wire logic        configFlagsOe,
	input wire logic        initLowOe,
	input wire logic        addrClock,
	input wire logic [15:0] memory_address_out,
	input wire logic        memAddrOe,
	input wire logic        write_strobe_out,
	input wire logic        periph_select2_n_out,
	input wire logic        serialDataOe,
	input wire logic        pullupEn,
	input wire logic        readbackShift,
	input wire logic        outputsActive,
	input wire logic        storageReset
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);
	AST_PDOWN_QUIET: assert property (!power_down_n [*8] |-> storageReset && !done_program_oe
		&& !config_clock_oe && !memAddrOe && !serialDataOe && !configFlagsOe)
		else $error("pins driven during power-down");
	AST_RESUME_DONE: assert property ($rose(power_down_n) |-> ##[4:9] done_program_oe [*8])
		else $error("done released too early after power-down");
	AST_STORE_CLEAR: assert property ((outputsActive && !configReset_n) [*6] |-> storageReset)
		else $error("storage not cleared by reset");
	AST_RB_DATA: assert property (readbackShift |-> mode1_readback_data_oe && !config_clock_oe
		&& mode1_readback_data_out == !$past(readbackBit))
		else $error("readback bit not inverted");
	AST_ADDR_LOW: assert property (memAddrOe |-> write_strobe_out == memory_address_out[0]
		&& periph_select2_n_out == memory_address_out[1])
		else $error("low address bits not on strobe pins");
	AST_ADDR_CLK: assert property (memAddrOe && $past(memAddrOe)
		&& $changed(memory_address_out) |-> $past(addrClock))
		else $error("address changed without address clock");
	AST_FLAGS: assert property (configFlagsOe |-> config_high_flag && !config_low_flag)
		else $error("configuration flags wrong");
	AST_USER_PINS: assert property (outputsActive |-> !configFlagsOe && !pullupEn && !initLowOe)
		else $error("configuration pins kept after start-up");
	AST_INIT_LOW: assert property (initLowOe |-> pullupEn && !serialDataOe && !memAddrOe)
		else $error("init low outside clearing");
	COV_RB: cover property (readbackShift);
	COV_START: cover property ($rose(outputsActive));
	COV_ADDR: cover property (memAddrOe && addrClock);
endmodule
bind fpga_config_pin_control fpga_config_pin_control_props i_props (.ref_clk, .nrst,
	.power_down_n, .configReset_n, .readbackBit, .config_clock_oe, .done_program_oe,
	.mode1_readback_data_out, .mode1_readback_data_oe, .config_high_flag, .config_low_flag,
	.configFlagsOe, .initLowOe, .addrClock, .memory_address_out, .memAddrOe, .write_strobe_out,
	.periph_select2_n_out, .serialDataOe, .pullupEn, .readbackShift, .outputsActive,
	.storageReset);

// >>> tb/tb.sv
// self-checking bench for the configuration pin controller
`timescale 1ns/100ps
module tb;
	logic                      ref_clk, nrst, power_down_n, configReset_n, pullDone, go;
	logic                      mode0_read_trigger, m1Drv, mode2_select, serialDataIn, cclkExt;
	logic                      cfgLoadDone, readbackBit, readbackLast, doneBeforeOutputs;
	logic                      config_clock_in, done_program_in, mode1_readback_data_in;
	logic                      config_clock_out, config_clock_oe, done_program_oe, readyBusy;
	logic                      mode1_readback_data_out, mode1_readback_data_oe, readyBusyOe;
	logic                      config_high_flag, config_low_flag, configFlagsOe, initLowOe;
	logic                      addrClock, addrClockOe, memAddrOe, write_strobe_out;
	logic                      periph_select2_n_out, serialDataOut, serialDataOe, pullupEn;
	logic                      cfgBit, cfgBitValid, readbackShift, outputsActive, storageReset;
	logic [15:0]               memory_address_out, pattern;
	logic [7:0]                nRises;
	fpga_cfg_pkg::periph_bus_t periphIn;
	fpga_cfg_pkg::rb_opt_t     readbackOption;
	logic                      qBit[$], qRb[$];
	int                        fails, n_checks, i, tDone, tOut;
	bit                        watchBits;
	// shared pins resolved
	assign config_clock_in = config_clock_oe ? config_clock_out : cclkExt;
	assign done_program_in = !(done_program_oe || pullDone);
	assign mode1_readback_data_in = mode1_readback_data_oe ? mode1_readback_data_out : m1Drv;
	fpga_config_pin_control #(.POR_TICKS_HI(4), .POR_TICKS_LO(8)) i_fpga_config_pin_control (.*);
	cfg_source_model i_cfg_source_model (.go, .nRises, .pattern, .cclkExt, .serialDataIn);
	////////////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic got, input logic exp);
		n_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch at %0t: got %b expected %b", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic burst(input int n);
		nRises = 8'(n);
		go = 1'b1;
		tick(1);
		go = 1'b0;
		tick(8 * n + 12);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// unexpected pulses meet x and fail; sampled off the launching edge
	always @(negedge ref_clk)
	begin
		if (cfgBitValid && watchBits)
			check(cfgBit, qBit.size() ? qBit.pop_front() : 1'bx);
		if (readbackShift)
			check(mode1_readback_data_out, qRb.size() ? qRb.pop_front() : 1'bx);
	end
	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	initial
	begin
		#2000000;
		fails++;
		tally_and_finish();
	end
	initial
	begin
		{nrst, configReset_n, pullDone, go, cfgLoadDone, m1Drv, mode0_read_trigger} = 7'h0;
		{power_down_n, mode2_select, readbackLast} = 3'h7;
		nRises = 8'h0;
		pattern = 16'($urandom(98));
		periphIn = '{3'h7, 1'b0, 8'($urandom)};
		readbackBit = 1'($urandom);
		doneBeforeOutputs = 1'($urandom);
		readbackOption = fpga_cfg_pkg::RB_ONCE;
		tick(4);
		nrst = 1'b1;
		tick(20);
		check(initLowOe, 1'b1);
		tick(400);
		check(memAddrOe, 1'b0);
		check(initLowOe, 1'b0);
		configReset_n = 1'b1;
		tick(12);
		check(memAddrOe && memory_address_out === fpga_cfg_pkg::ADDR_LOW_START, 1'b1);
		for (i = 0; i < 100 && addrClock !== 1'b1; i++)
			tick(1);
		tick(12);
		check(memory_address_out === fpga_cfg_pkg::ADDR_LOW_START + 16'h1, 1'b1);
		configReset_n = 1'b0;
		{mode0_read_trigger, m1Drv} = 2'h3;
		tick(20);
		check(initLowOe, 1'b1);
		configReset_n = 1'b1;
		tick(200);
		check(config_clock_oe, 1'b0);
		watchBits = 1'b1;
		for (i = 15; i >= 0; i--)
			qBit.push_back(pattern[i]);
		burst(16);
		check(qBit.size() == 0, 1'b1);
		watchBits = 1'b0;
		cfgLoadDone = 1'b1;
		tick(1);
		cfgLoadDone = 1'b0;
		for (i = 0; i < 60 && (done_program_oe !== 1'b0 || outputsActive !== 1'b1); i++)
		begin
			if (done_program_oe)
				tDone = i + 1;
			if (!outputsActive)
				tOut = i + 1;
			tick(1);
		end
		check((doneBeforeOutputs ? tOut - tDone : tDone - tOut) == 10, 1'b1);
		check(configFlagsOe | pullupEn | serialDataOe, 1'b0);
		// second trigger refused when only one readback allowed
		for (i = 0; i < 2; i++)
		begin
			mode0_read_trigger = 1'b0;
			tick(10);
			if (i == 0)
				qRb.push_back(~readbackBit);
			mode0_read_trigger = 1'b1;
			tick(10);
			burst(3);
			check(qRb.size() == 0, 1'b1);
		end
		power_down_n = 1'b0;
		tick(20);
		check(storageReset && !outputsActive, 1'b1);
		power_down_n = 1'b1;
		tick(12);
		check(done_program_oe, 1'b1);
		tick(40);
		check(outputsActive && !done_program_oe, 1'b1);
		configReset_n = 1'b0;
		tick(10);
		check(storageReset, 1'b1);
		configReset_n = 1'b1;
		pullDone = 1'b1;
		tick(10);
		pullDone = 1'b0;
		tick(20);
		check(initLowOe && !outputsActive, 1'b1);
		tally_and_finish();
	end
endmodule
